//--- logic/pdt_pkg.sv
// Package of constants and types for the pulse and delay timer block
package pdt_pkg;
    // Clock and time base
    localparam int CLK_HZ      = 40_000_000;
    localparam int TICK_MS     = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // Fine units of the stairwell counter per time base, in ms
    localparam int FINE_SEC_MS  = 50;
    localparam int FINE_MIN_MS  = 1000;
    localparam int FINE_HOUR_MS = 60000;
    localparam logic [12:0] FINE_SEC_TICKS  = 13'(FINE_SEC_MS / TICK_MS);
    localparam logic [12:0] FINE_MIN_TICKS  = 13'(FINE_MIN_MS / TICK_MS);
    localparam logic [12:0] FINE_HOUR_TICKS = 13'(FINE_HOUR_MS / TICK_MS);
    // Fine units per base unit of T
    localparam logic [5:0] MULT_SEC  = 6'h14;
    localparam logic [5:0] MULT_MIN  = 6'h3c;
    localparam logic [5:0] MULT_HOUR = 6'h3c;
    // Fixed prewarning start and length, in fine units
    localparam logic [15:0] PW_DEF_START = 16'h000f;
    localparam logic [15:0] PW_DEF_LEN   = 16'h0001;
    // Register indices
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_PRM0 = 8'h01;
    localparam logic [7:0] A_SRC  = 8'h09;
    localparam logic [7:0] A_STAT = 8'h0a;
    localparam logic [7:0] A_EL0  = 8'h0b;
    // Parameter slots
    localparam int P_SYM = 0;
    localparam int P_AH  = 1;
    localparam int P_AL  = 2;
    localparam int P_RH  = 3;
    localparam int P_RL  = 4;
    localparam int P_ST  = 5;
    localparam int P_PWS = 6;
    localparam int P_PWL = 7;
    localparam int N_PRM = 8;
    // Control bit positions
    localparam int C_PW_EN   = 0;
    localparam int C_PW_USER = 1;
    localparam int C_RETRIG  = 2;
    localparam int C_RETAIN  = 3;
    localparam int C_TB_LO   = 4;
    localparam logic [5:0] CTRL_RESET = 6'h01;
    // Parameter reset value: 0.1 s in ticks
    localparam logic [15:0] PRM_RESET = 16'h000a;
    typedef enum logic [1:0] {
        TB_SEC  = 2'b00,
        TB_MIN  = 2'b01,
        TB_HOUR = 2'b10
    } pdt_tb_t;
    typedef enum logic [1:0] {
        RND_IDLE = 2'b00,
        RND_ON   = 2'b01,
        RND_OFF  = 2'b10
    } pdt_rnd_t;
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b10
    } pdt_st_t;
endpackage

//--- logic/pdt_timers.sv
// Symmetrical, asynchronous, random and stairwell timer functions
//
// Contract
// R1: Symmetric generator: high T, low T, repeat.
// R2: Program symmetric period 0.1 s only; P_SYM resets to 0.1 s but any written value is used.
// R3: Async generator: high time then low time.
// R4: Invert acts only while async enabled.
// R5: Any time parameter may use live value.
// R6: Enable rise picks random on-delay, starts it.
// R7: On-delay expiry sets output; fall cancels.
// R8: Enable fall picks random off-delay, starts it.
// R9: Off-delay expiry clears output; rise cancels.
// R10: Trigger starts off-delay; output low at T.
// R11: Optional prewarning with start and length.
// R12: Default prewarning fixed; user values ignored.
// R13: Prewarning scales with T's time base.
// R14: Seconds base only with scan below 25 ms.
// R15: Retentive option keeps stairwell state.
// R16: Trigger rise sets output; fall starts count.
// R17: Prewarning drives output low for length.
// R18: Optional restart on further trigger fall.
// R19: Random delays from scaled free-running LFSR.
// R20: Timers count common tick, compared per tick.
`timescale 1ns/1ps
module pdt_timers #(
    parameter int TICK_CYCLES = pdt_pkg::TICK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        power_up_i,
    input  wire logic        sym_en_i,
    input  wire logic        async_en_i,
    input  wire logic        async_inv_i,
    input  wire logic        rnd_en_i,
    input  wire logic        stair_trg_i,
    output logic             sym_q_o,
    output logic             async_q_o,
    output logic             rnd_q_o,
    output logic             stair_q_o
);
    import pdt_pkg::*;

    // All state in one packed word: one process forms the next value,
    // one registers it, so the clock enable gates everything at once
    typedef struct packed {
        logic [31:0]             tick_cnt;
        logic [12:0]             fine_cnt;
        logic [5:0]              ctrl;
        logic [N_PRM-1:0][15:0]  prm;
        logic [N_PRM-1:0][2:0]   src;
        logic [31:0]             rdata;
        logic [15:0]             lfsr;
        logic                    sym_q;
        logic                    sym_run;
        logic [15:0]             sym_cnt;
        logic                    as_ph;
        logic                    as_run;
        logic [15:0]             as_cnt;
        logic                    as_q;
        pdt_rnd_t                rnd_st;
        logic [15:0]             rnd_cnt;
        logic [15:0]             rnd_dly;
        logic                    rnd_q;
        logic                    rnd_en_d;
        pdt_st_t                 st_st;
        logic [21:0]             st_cnt;
        logic                    st_q;
        logic                    trg_d;
    } pdt_state_t;

    pdt_state_t s;
    pdt_state_t next_s;

    // Live counters offered as parameter sources, one per function
    logic [3:0][15:0]     elapsed;
    logic [N_PRM-1:0][15:0] eff;

    // Live elapsed values that other parameters may borrow
    assign elapsed[0] = s.sym_cnt;
    assign elapsed[1] = s.as_cnt;
    assign elapsed[2] = s.rnd_cnt;
    // The stairwell count is 22 bits wide; only its low 16 bits are offered
    assign elapsed[3] = s.st_cnt[15:0];

    // Each parameter picks its constant or a block's live value
    genvar g;
    generate
        // Bit 2 of a source selects live, bits 1:0 pick the counter
        for (g = 0; g < N_PRM; g++) begin : g_src
            assign eff[g] = s.src[g][2] ? elapsed[s.src[g][1:0]]
                                        : s.prm[g]; // see R5
        end
    endgenerate

    // Random delay scaled to the limit from the current LFSR word;
    // keeping the upper half of the product stays below the limit
    function automatic logic [15:0] scale(input logic [15:0] rnd,
                                          input logic [15:0] lim);
        logic [31:0] p;
        p = 32'(rnd) * 32'(lim);
        return p[31:16];
    endfunction

    // Time base, prewarning window and input edge detection
    logic        tick;
    logic        fine_tick;
    logic [12:0] fine_div;
    logic [5:0]  mult;
    logic [21:0] t_fine;
    logic [21:0] pw_start;
    logic [21:0] pw_len;
    logic [21:0] pw_at;
    logic        in_pw;
    logic        rnd_rise;
    logic        rnd_fall;
    logic        trg_rise;
    logic        trg_fall;

    // Time base decode for the stairwell fine unit
    always_comb begin
        unique case (pdt_tb_t'(s.ctrl[C_TB_LO +: 2]))
            TB_MIN: begin
                fine_div = FINE_MIN_TICKS;
                mult     = MULT_MIN;
            end
            TB_HOUR: begin
                fine_div = FINE_HOUR_TICKS;
                mult     = MULT_HOUR;
            end
            default: begin // TB_SEC and the unused code
                fine_div = FINE_SEC_TICKS;
                mult     = MULT_SEC;
            end
        endcase
    end

    // Prescalers are state too, so ticks pause while ce_i is low
    assign tick      = (s.tick_cnt == 32'(TICK_CYCLES - 1)); // see R20
    assign fine_tick = tick && (s.fine_cnt == fine_div - 13'h0001);
    // Widen before the product; T times the multiplier needs 22 bits
    assign t_fine    = 22'(eff[P_ST]) * 22'(mult); // see R13
    // User prewarning only when selected, else fixed values
    assign pw_start  = s.ctrl[C_PW_USER] ? 22'(eff[P_PWS])
                                         : 22'(PW_DEF_START); // see R12
    assign pw_len    = s.ctrl[C_PW_USER] ? 22'(eff[P_PWL])
                                         : 22'(PW_DEF_LEN); // see R13
    // Clamp start so a long prewarning never wraps below zero
    assign pw_at     = (t_fine > pw_start) ? t_fine - pw_start : 22'h0;
    assign rnd_rise  = rnd_en_i && !s.rnd_en_d;
    assign rnd_fall  = !rnd_en_i && s.rnd_en_d;
    assign trg_rise  = stair_trg_i && !s.trg_d;
    assign trg_fall  = !stair_trg_i && s.trg_d;

    // Next-state logic for all four functions and the register port
    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0;
        // Common tick prescaler and fine-unit prescaler; the fine count
        // idles at zero outside the run state so each run starts clean
        next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;
        if (fine_tick || (s.st_st != ST_RUN)) begin
            next_s.fine_cnt = 13'h0;
        end else if (tick) begin
            next_s.fine_cnt = s.fine_cnt + 13'h1;
        end
        // Free-running LFSR, taps 16,14,13,11; it keeps running between
        // requests, so delays depend on when the enable edge arrives
        next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^
                       s.lfsr[12] ^ s.lfsr[10]}; // see R19

        // Symmetrical generator: first half period is high. A period
        // below one tick is not meaningful and toggles every tick
        if (!sym_en_i) begin
            next_s.sym_q   = 1'b0; // see R1
            next_s.sym_run = 1'b0;
            next_s.sym_cnt = 16'h0;
        end else if (!s.sym_run) begin
            next_s.sym_q   = 1'b1;
            next_s.sym_run = 1'b1;
            next_s.sym_cnt = 16'h0;
        end else if (tick) begin
            if (s.sym_cnt + 16'h1 >= eff[P_SYM]) begin // see R1
                next_s.sym_q   = !s.sym_q;
                next_s.sym_cnt = 16'h0;
            end else begin
                next_s.sym_cnt = s.sym_cnt + 16'h1;
            end
        end

        // Asynchronous generator with separate high and low times; the
        // phase flips on the tick that completes the active time
        if (!async_en_i) begin
            next_s.as_ph  = 1'b0;
            next_s.as_run = 1'b0;
            next_s.as_cnt = 16'h0;
        end else if (!s.as_run) begin
            next_s.as_ph  = 1'b1;
            next_s.as_run = 1'b1;
            next_s.as_cnt = 16'h0;
        end else if (tick) begin
            if (s.as_cnt + 16'h1 >= (s.as_ph ? eff[P_AH]
                                             : eff[P_AL])) begin // see R3
                next_s.as_ph  = !s.as_ph;
                next_s.as_cnt = 16'h0;
            end else begin
                next_s.as_cnt = s.as_cnt + 16'h1;
            end
        end
        // Inversion is masked while disabled
        next_s.as_q = async_en_i &&
                      (next_s.as_ph ^ async_inv_i); // see R4

        // Random generator: edges pick a fresh delay and restart.
        // Expiry is judged on ticks, so a zero delay still waits for one
        next_s.rnd_en_d = rnd_en_i;
        if (rnd_rise) begin
            next_s.rnd_st  = RND_ON; // see R6
            next_s.rnd_cnt = 16'h0;
            next_s.rnd_dly = scale(s.lfsr, eff[P_RH]);
        end else if (rnd_fall) begin
            // Pending on-delay dropped, output untouched
            next_s.rnd_st  = RND_OFF; // see R7 and R8
            next_s.rnd_cnt = 16'h0;
            next_s.rnd_dly = scale(s.lfsr, eff[P_RL]);
        end else if (tick && (s.rnd_st != RND_IDLE)) begin
            if (s.rnd_cnt >= s.rnd_dly) begin
                next_s.rnd_q  = (s.rnd_st == RND_ON); // see R7 and R9
                next_s.rnd_st = RND_IDLE;
            end else begin
                next_s.rnd_cnt = s.rnd_cnt + 16'h1;
            end
        end

        // Stairwell light: rise holds on, fall starts off-delay. With
        // retrigger off, a rise while running is ignored
        next_s.trg_d = stair_trg_i;
        unique case (s.st_st)
            ST_OFF: begin
                if (trg_rise) begin
                    next_s.st_st = ST_HOLD; // see R16
                end
            end
            ST_HOLD: begin
                if (trg_fall) begin
                    next_s.st_st  = ST_RUN; // see R16
                    next_s.st_cnt = 22'h0;
                end
            end
            ST_RUN: begin
                if (trg_rise && s.ctrl[C_RETRIG]) begin
                    next_s.st_st  = ST_HOLD; // see R18
                    next_s.st_cnt = 22'h0;
                end else if (fine_tick) begin
                    if (s.st_cnt + 22'h1 >= t_fine) begin
                        next_s.st_st  = ST_OFF; // see R10
                        next_s.st_cnt = 22'h0;
                    end else begin
                        next_s.st_cnt = s.st_cnt + 22'h1;
                    end
                end
            end
            default: begin
                next_s.st_st = ST_OFF;
            end
        endcase
        // Window judged on the updated count, so the dip begins on the
        // fine tick itself and lasts exactly the prewarning length
        in_pw = s.ctrl[C_PW_EN] && (next_s.st_st == ST_RUN) &&
                (next_s.st_cnt >= pw_at) &&
                (next_s.st_cnt < pw_at + pw_len); // see R11
        next_s.st_q = (next_s.st_st != ST_OFF) && !in_pw; // see R17

        // Power-up restart keeps the stairwell only when retentive; the
        // retained count and output then resume where they stopped
        if (power_up_i) begin
            next_s.sym_run = 1'b0;
            next_s.as_run  = 1'b0;
            next_s.rnd_st  = RND_IDLE;
            next_s.rnd_q   = 1'b0;
            if (!s.ctrl[C_RETAIN]) begin // see R15
                next_s.st_st  = ST_OFF;
                next_s.st_cnt = 22'h0;
                next_s.st_q   = 1'b0;
            end
        end

        // Register writes land on the next enabled edge; unmapped
        // addresses are ignored rather than aliased
        if (wr_i) begin
            if (addr_i == A_CTRL) begin
                next_s.ctrl = wdata_i[5:0];
            end else if (addr_i == A_SRC) begin
                next_s.src = wdata_i[3*N_PRM-1:0];
            end else if (addr_i >= A_PRM0 &&
                         addr_i < A_PRM0 + 8'(N_PRM)) begin
                next_s.prm[3'(addr_i - A_PRM0)] = wdata_i[15:0];
            end
        end
        // Register reads answer in the next cycle, unmapped as zero
        if (rd_i) begin
            if (addr_i == A_CTRL) begin
                next_s.rdata = 32'(s.ctrl);
            end else if (addr_i == A_SRC) begin
                next_s.rdata = 32'(s.src);
            end else if (addr_i == A_STAT) begin
                next_s.rdata = {26'h0, s.st_st, s.st_q, s.rnd_q,
                                s.as_q, s.sym_q};
            end else if (addr_i >= A_PRM0 &&
                         addr_i < A_PRM0 + 8'(N_PRM)) begin
                next_s.rdata = 32'(s.prm[3'(addr_i - A_PRM0)]);
            end else if (addr_i >= A_EL0 && addr_i < A_EL0 + 8'h4) begin
                next_s.rdata = 32'(elapsed[2'(addr_i - A_EL0)]);
            end
        end
    end

    // State register; clock enable freezes every bit. Reset loads
    // only constants: the default control word, 0.1 s periods and the LFSR seed
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s          <= '0;
            s.ctrl     <= CTRL_RESET;
            s.prm      <= {N_PRM{PRM_RESET}};
            s.lfsr     <= 16'hace1; // Nonzero seed, LFSR never locks
            s.rnd_st   <= RND_IDLE;
            s.st_st    <= ST_OFF;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // Every output comes straight from a state flop
    assign rdata_o   = s.rdata;
    assign sym_q_o   = s.sym_q;
    assign async_q_o = s.as_q;
    assign rnd_q_o   = s.rnd_q;
    assign stair_q_o = s.st_q;
endmodule

//--- tb/pdt_timers_props.sv
// Concurrent checks on the ports of the timer block
`timescale 1ns/1ps
module pdt_timers_props
    import pdt_pkg::*;
#(
    parameter int TICK_CYCLES = 4
) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        ce_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        power_up_i,
    input wire logic        sym_en_i,
    input wire logic        async_en_i,
    input wire logic        async_inv_i,
    input wire logic        rnd_en_i,
    input wire logic        stair_trg_i,
    input wire logic        sym_q_o,
    input wire logic        async_q_o,
    input wire logic        rnd_q_o,
    input wire logic        stair_q_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Accepted read strobe
    sequence s_rd;
        ce_i && rd_i;
    endsequence
    // Enable edges seen on two running cycles, no restart pending
    sequence s_async_rise;
        ce_i && $past(ce_i) && async_en_i && !$past(async_en_i) && !power_up_i;
    endsequence
    sequence s_sym_rise;
        ce_i && $past(ce_i) && sym_en_i && !$past(sym_en_i) && !power_up_i;
    endsequence
    // Read data only in the cycle after an accepted read
    chk_rd_quiet: assert property (!$past(ce_i && rd_i) |-> rdata_o == 32'h0)
        else $error("read data not idle");
    chk_rd_unmapped: assert property (s_rd ##0 addr_i > 8'h0e
        |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_stat_mirror: assert property (s_rd ##0 addr_i == A_STAT
        |=> rdata_o[3:0] == $past({stair_q_o, rnd_q_o, async_q_o, sym_q_o}))
        else $error("status does not mirror outputs");
    chk_async_off: assert property (ce_i && !async_en_i
        |=> !async_q_o)
        else $error("async output high while disabled");
    chk_async_start: assert property (s_async_rise
        |=> async_q_o == !$past(async_inv_i))
        else $error("async start level wrong");
    chk_sym_start: assert property (s_sym_rise |=> sym_q_o)
        else $error("sym output not set on enable");
    chk_sym_idle: assert property (ce_i && !sym_en_i && !sym_q_o
        |=> !sym_q_o)
        else $error("sym output rose while disabled");
    chk_rnd_rise_en: assert property ($rose(rnd_q_o)
        |-> $past(rnd_en_i))
        else $error("random output set without enable");
    chk_rnd_fall_en: assert property ($fell(rnd_q_o)
        |-> !$past(rnd_en_i) || $past(power_up_i))
        else $error("random output cleared with enable high");
    chk_freeze_hold: assert property (!ce_i
        |=> $stable({sym_q_o, async_q_o, rnd_q_o, stair_q_o}))
        else $error("outputs moved while frozen");
endmodule

bind pdt_timers pdt_timers_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .power_up_i(power_up_i), .sym_en_i(sym_en_i), .async_en_i(async_en_i),
    .async_inv_i(async_inv_i), .rnd_en_i(rnd_en_i),
    .stair_trg_i(stair_trg_i), .sym_q_o(sym_q_o), .async_q_o(async_q_o),
    .rnd_q_o(rnd_q_o), .stair_q_o(stair_q_o));

//--- tb/pdt_prog_model.sv
// Model of the user program that drives the timer function inputs
`timescale 1ns/1ps
module pdt_prog_model (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [4:0] req_i,
    output logic            sym_en_o,
    output logic            async_en_o,
    output logic            async_inv_o,
    output logic            rnd_en_o,
    output logic            stair_trg_o
);
    // Program scan time; seconds base is only chosen with fast scans
    localparam int SCAN_MS = 10;
    logic [4:0] img;
    // Process image updates on every clock, so levels lag a request by one cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            img <= 5'h00;
        end else begin
            img <= req_i;
        end
    end
    // Image bits fan out to the function inputs
    assign sym_en_o    = img[0];
    assign async_en_o  = img[1];
    assign async_inv_o = img[2];
    assign rnd_en_o    = img[3];
    assign stair_trg_o = img[4];
endmodule

//--- tb/pulse_delay_timer_functions_tb_top.sv
// Self-checking bench for the timer function block
`timescale 1ns/1ps
module pulse_delay_timer_functions_tb_top;
    import pdt_pkg::*;
    localparam int TC = 4;
    logic        clk_i, reset_n_i, ce_i, wr_i, rd_i, power_up_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [4:0]  req;
    logic [4:0]  lv;
    logic [3:0]  q;
    int          n_errors, total_checks;

    pdt_prog_model i_prog (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .req_i(req), .sym_en_o(lv[0]), .async_en_o(lv[1]),
        .async_inv_o(lv[2]), .rnd_en_o(lv[3]), .stair_trg_o(lv[4]));
    pdt_timers #(.TICK_CYCLES(TC)) i_dut (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .power_up_i(power_up_i), .sym_en_i(lv[0]), .async_en_i(lv[1]),
        .async_inv_i(lv[2]), .rnd_en_i(lv[3]), .stair_trg_i(lv[4]),
        .sym_q_o(q[0]), .async_q_o(q[1]), .rnd_q_o(q[2]),
        .stair_q_o(q[3]));

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data is looked at in the one cycle where it stands
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask
    // Counts cycles until an output reaches a level, capped at lim
    task automatic wait_q(input int i, input logic v, input int lim,
                          output int n);
        n = 1;
        @(negedge clk_i);
        while (q[i] !== v && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic t_regs();
        logic [31:0] d;
        rd(A_CTRL, d);
        chk(d, 32'h1, "ctrl reset");
        rd(A_PRM0 + 8'(P_SYM), d);
        chk(d, 32'ha, "sym period reset");
        wr(8'h3f, 32'h5);
        rd(8'h3f, d);
        chk(d, 32'h0, "unmapped read");
        wr(A_STAT, 32'hff);
        rd(A_STAT, d);
        chk(d, 32'h0, "status not read only");
        @(posedge clk_i);
        ce_i <= 1'b0;
        rd(A_CTRL, d);
        chk(d, 32'h0, "read while frozen");
        @(posedge clk_i);
        ce_i <= 1'b1;
        $display("test regs done");
    endtask
    task automatic t_sym();
        int n;
        req[0] <= 1'b1;
        wait_q(0, 1'b1, 20, n);
        wait_q(0, 1'b0, 100, n);
        wait_q(0, 1'b1, 100, n);
        chk(n, 10 * TC, "sym low time");
        wait_q(0, 1'b0, 100, n);
        chk(n, 10 * TC, "sym high time");
        wait_q(0, 1'b1, 100, n);
        @(posedge clk_i);
        req[0] <= 1'b0;
        wait_q(0, 1'b0, 100, n);
        chk(n < 8, 1'b1, "sym not stopped");
        wait_q(0, 1'b1, 100, n);
        chk(n, 100, "sym restarted while disabled");
        $display("test sym done");
    endtask
    task automatic t_async();
        int n;
        wr(A_PRM0 + 8'(P_AH), 32'h3);
        wr(A_PRM0 + 8'(P_AL), 32'h5);
        req[1] <= 1'b1;
        wait_q(1, 1'b1, 20, n);
        wait_q(1, 1'b0, 100, n);
        wait_q(1, 1'b1, 100, n);
        chk(n, 5 * TC, "async low time");
        @(posedge clk_i);
        req[2] <= 1'b1;
        wait_q(1, 1'b0, 4, n);
        chk(n < 4, 1'b1, "invert not applied");
        @(posedge clk_i);
        req[1] <= 1'b0;
        wait_q(1, 1'b0, 4, n);
        wait_q(1, 1'b1, 3, n);
        wait_q(1, 1'b0, 100, n);
        wait_q(1, 1'b1, 40, n);
        chk(n, 40, "invert acts while disabled");
        req[2] <= 1'b0;
        $display("test async done");
    endtask
    task automatic t_rnd();
        int n;
        wr(A_PRM0 + 8'(P_RH), 32'h5);
        wr(A_PRM0 + 8'(P_RL), 32'h2);
        req[3] <= 1'b1;
        wait_q(2, 1'b1, 7 * TC, n);
        chk(n < 7 * TC, 1'b1, "on-delay beyond limit");
        @(posedge clk_i);
        req[3] <= 1'b0;
        wait_q(2, 1'b0, 4 * TC, n);
        chk(n < 4 * TC, 1'b1, "off-delay beyond limit");
        $display("test rnd done");
    endtask
    task automatic t_stair(input logic [5:0] ctrl, input int m, f, s, l);
        int n;
        wr(A_CTRL, 32'(ctrl));
        req[4] <= 1'b1;
        wait_q(3, 1'b1, 8, n);
        chk(n < 8, 1'b1, "stair not set on trigger");
        @(posedge clk_i);
        req[4] <= 1'b0;
        wait_q(3, 1'b0, 2 * m * f, n);
        chk(n >= (m - s - 1) * f && n <= (m - s + 1) * f, 1'b1,
            "prewarn start");
        wait_q(3, 1'b1, 2 * m * f, n);
        chk(n, l * f, "prewarn length");
        wait_q(3, 1'b0, 2 * m * f, n);
        chk(n, (s - l) * f, "off-delay end");
        wait_q(3, 1'b1, 40, n);
        chk(n, 40, "stair stays off");
        $display("test stair done");
    endtask
    // Second fall restarts the full off-delay of 20 fine units
    task automatic t_retrig();
        int n;
        wr(A_CTRL, 32'h4);
        req[4] <= 1'b1;
        repeat (4) @(posedge clk_i);
        req[4] <= 1'b0;
        repeat (200) @(posedge clk_i);
        req[4] <= 1'b1;
        repeat (4) @(posedge clk_i);
        req[4] <= 1'b0;
        wait_q(3, 1'b0, 500, n);
        chk(n >= 20 * 5 * TC && n < 21 * 5 * TC, 1'b1,
            "retrigger restart");
        $display("test retrig done");
    endtask
    task automatic t_retain(input logic [5:0] ctrl, input logic keep);
        int n;
        wr(A_CTRL, 32'(ctrl));
        req[4] <= 1'b1;
        repeat (4) @(posedge clk_i);
        req[4] <= 1'b0;
        repeat (8) @(posedge clk_i);
        power_up_i <= 1'b1;
        @(posedge clk_i);
        power_up_i <= 1'b0;
        wait_q(3, 1'b0, 4, n);
        chk(n == 4, keep, "retentive state");
        repeat (500) @(posedge clk_i);
        $display("test retain done");
    endtask

    // Hang guard sized well above the longest stairwell run
    initial begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        test_done();
    end

    initial begin
        {reset_n_i, ce_i, wr_i, rd_i, power_up_i} = 5'h00;
        {addr_i, wdata_i, req} = '0;
        n_errors = 0;
        total_checks = 0;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        ce_i <= 1'b1;
        t_regs();
        t_sym();
        t_async();
        t_rnd();
        wr(A_PRM0 + 8'(P_ST), 32'h1);
        wr(A_PRM0 + 8'(P_PWS), 32'h4);
        wr(A_PRM0 + 8'(P_PWL), 32'h2);
        t_stair(6'h01, 20, 5 * TC, 15, 1);
        t_stair(6'h03, 20, 5 * TC, 4, 2);
        t_stair(6'h11, 60, 100 * TC, 15, 1);
        t_retrig();
        t_retain(6'h09, 1'b1);
        t_retain(6'h01, 1'b0);
        test_done();
    end
endmodule
